// ### sfm_detectors.sv
// detector-side model: fault detectors, status snapshot, filtered speed, power stage
// assumes the fault manager's pclk; the bench calls put right after a rising edge
`timescale 1ns/1ps
module sfm_detectors (
	input wire logic pclk, // clock
	output logic [19:0] det, // detector levels
	output logic [15:0] snap, // status snapshot
	output logic signed [15:0] speed, // filtered speed
	output logic power_ok // power stage ready
);
	initial begin
		det = 20'h00000;
		snap = 16'h0000;
		speed = 16'sh0000;
		power_ok = 1'b1;
	end
	task put(input logic [19:0] m, input logic [15:0] s, input logic signed [15:0] v);
		det <= m;
		snap <= s;
		speed <= v;
	endtask : put
	task set_power(input logic b);
		power_ok <= b;
	endtask : set_power
endmodule : sfm_detectors

// ### sfm_fault_mgr.sv
// servo fault manager: latches detector faults, history log, display code,
// status outputs, apb register slave.
// assumes detectors and speed filter run on pclk; servo enable and probes are pins.
// How it works
// - ten newest faults logged with status snapshot
// - repeat within five newest entries logged once
// - display shows code of most severe active
// - reset keeps log; clear-log write erases it
// - each code falls in one of three categories
// - groups 0x to 3x severe, never cleared
// - groups 4x to 7x severe, reset clears
// - groups 8x to Cx category two, resettable
// - reset request drops resettable code from display
// - host writes one to fault reset
// - reset honoured only while servo enable off
// - alarms clear themselves when source goes
// - threshold changes apply only with enable off
// - software mismatch 0x010, bus 0x6100, fixed
// - motor parameter mismatch 0x011, bus 0x7122
// - product matching faults 0x020-0x022, bus 0x6100
// - serial check failure 0x053, bus 0x7500
// - out-of-control 0x060, bus 0x8400, fixed
// - rotating output when speed magnitude reaches threshold
// - ready output when enable can be accepted
// - fault output while unreset fault exists
// - warning output while alarm pending
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "sfm_map.svh"
module sfm_fault_mgr #(
	parameter int N_SRC = `SFM_NSRC, // detector count
	parameter int HIST_DEPTH = `SFM_HIST, // log entries
	parameter int DUP_WIN = `SFM_DUP_WIN, // duplicate window
	parameter logic [11:0] CAT2_CODE = 12'h800, // category two source code
	parameter logic [15:0] CAT2_BUS = 16'hFF00, // its bus code
	parameter logic [11:0] ALM_CODE = 12'hD00, // alarm source code
	parameter logic [15:0] ALM_BUS = 16'hFF00 // its bus code
) (
	input wire logic pclk, // clock, 40 MHz
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped
	input wire logic [N_SRC-1:0] det_in, // detector levels
	input wire logic [15:0] snap_in, // drive status snapshot
	input wire logic signed [15:0] speed_in, // filtered speed
	input wire logic power_ok_in, // power stage ready
	input wire logic servo_en_in, // servo enable pin
	input wire logic probe_one_in, // touch probe 1 pin
	input wire logic probe_two_in, // touch probe 2 pin
	output logic servo_ready_out, // servo ready
	output logic motor_rotating_out, // motor rotating
	output logic brake_out, // brake released
	output logic warn_out, // alarm pending
	output logic fault_out, // fault pending
	output sfm_pkg::sfm_code_t internal_fault_code_obj, // shown code
	output sfm_pkg::sfm_bus_t bus_error_code_obj // shown bus code
);
	import sfm_pkg::*;

	if (N_SRC != `SFM_NSRC || HIST_DEPTH != `SFM_HIST || DUP_WIN > HIST_DEPTH) begin : g_chk
		$error("sfm_fault_mgr: unsupported parameter values");
	end

	sfm_state_s st;
	sfm_state_s next_st;

	function automatic sfm_info_s info_of(input int i);
		sfm_info_s r;
		r = '0;
		case (i)
			0: r = '{12'h010, 16'h6100};
			1: r = '{12'h011, 16'h7122};
			2: r = '{12'h020, 16'h6100};
			3: r = '{12'h021, 16'h6100};
			4: r = '{12'h022, 16'h6100};
			5: r = '{12'h030, 16'h6320};
			6: r = '{12'h031, 16'h6320};
			7: r = '{12'h032, 16'h6320};
			8: r = '{12'h033, 16'h6320};
			9: r = '{12'h050, 16'h7500};
			10: r = '{12'h051, 16'h7500};
			11: r = '{12'h052, 16'h7500};
			12: r = '{12'h053, 16'h7500};
			13: r = '{12'h060, 16'h8400};
			14: r = '{12'h100, 16'h2312};
			15: r = '{12'h101, 16'h2312};
			16: r = '{12'h400, 16'h3230};
			17: r = '{12'h460, 16'h8400};
			18: r = '{CAT2_CODE, CAT2_BUS};
			19: r = '{ALM_CODE, ALM_BUS};
			default: r = '0;
		endcase
		return r;
	endfunction : info_of

	function automatic sfm_code_t code_of(input int i);
		sfm_info_s r;
		r = info_of(i);
		return r.code;
	endfunction : code_of

	function automatic sfm_bus_t bus_of(input int i);
		sfm_info_s r;
		r = info_of(i);
		return r.bus;
	endfunction : bus_of

	// category from the group nibble
	function automatic sfm_cat_e cat_of(input sfm_code_t c);
		sfm_cat_e k;
		if (c[11:8] >= `SFM_GRP_ALM)
			k = SFM_CAT3;
		else if (c[11:8] >= `SFM_GRP_CAT2)
			k = SFM_CAT2;
		else
			k = SFM_CAT1;
		return k;
	endfunction : cat_of

	// lowest set index, table is in ascending code order
	function automatic int lowest(input logic [N_SRC-1:0] v);
		int r;
		r = 0;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (v[i])
				r = i;
		end
		return r;
	endfunction : lowest

	function automatic logic [16:0] mag(input logic signed [15:0] v);
		logic signed [16:0] w;
		w = {v[15], v};
		return v[15] ? 17'(-w) : 17'(w);
	endfunction : mag

	logic [N_SRC-1:0] res_m;
	logic [N_SRC-1:0] alarm_m;
	logic [N_SRC-1:0] nonres_m;
	for (genvar g = 0; g < N_SRC; g++) begin : g_mask
		assign alarm_m[g] = cat_of(code_of(g)) == SFM_CAT3;
		assign res_m[g] = code_of(g) >= {`SFM_GRP_RES, 8'h00};
		assign nonres_m[g] = ~res_m[g];
	end

	logic acc;
	logic wr;
	logic rst_req;
	logic clr_req;
	logic rec;
	int rec_idx;
	sfm_code_t rec_code;
	logic dup;
	logic [16:0] spd_mag;

	assign acc = psel & penable & st.pready;
	assign wr = acc & pwrite;
	assign rst_req = wr && paddr == `SFM_OFS_CTRL && pwdata[`SFM_BIT_RST];
	assign clr_req = wr && paddr == `SFM_OFS_CTRL && pwdata[`SFM_BIT_CLR];
	assign rec = |st.pend;
	assign rec_idx = lowest(st.pend);
	assign rec_code = code_of(rec_idx);
	assign spd_mag = mag(speed_in);

	always_comb begin
		dup = 1'b0;
		for (int j = 0; j < DUP_WIN; j++) begin
			if (st.hvalid[j] && st.hist[j].code == rec_code)
				dup = 1'b1;
		end
	end

	always_comb begin
		logic [31:0] rd_val;
		logic rd_hit;
		logic [11:0] hi;
		logic en_on;
		sfm_cat_e best;
		int best_i;
		rd_val = '0;
		rd_hit = 1'b1;
		hi = 12'((paddr - `SFM_OFS_HIST) >> 2);
		en_on = st.en_sync[1];
		best = SFM_CAT_NONE;
		best_i = 0;
		next_st = st;

		next_st.en_sync = {st.en_sync[0], servo_en_in};
		next_st.p1_sync = {st.p1_sync[0], probe_one_in};
		next_st.p2_sync = {st.p2_sync[0], probe_two_in};

		// register read decode
		case (paddr)
			`SFM_OFS_CTRL: rd_val = '0;
			`SFM_OFS_THR: rd_val = {16'h0000, st.thr_pend};
			`SFM_OFS_STAT: begin
				rd_val[`SFM_STAT_HV +: `SFM_HIST] = st.hvalid;
				rd_val[9:0] = {st.thr == st.thr_pend, st.p2_sync[1], st.p1_sync[1],
					en_on, st.brake, st.rot, st.ready, st.warn, st.fault, rec};
			end
			`SFM_OFS_CODE: rd_val = {20'h00000, st.code};
			`SFM_OFS_BUSC: rd_val = {16'h0000, st.bus};
			`SFM_OFS_ACT: rd_val = 32'(st.act);
			default: begin
				if (paddr >= `SFM_OFS_HIST && paddr[1:0] == 2'b00 && hi < 12'(HIST_DEPTH)) begin
					if (st.hvalid[hi[3:0]])
						rd_val = {4'h0, st.hist[hi[3:0]]};
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase

		// one wait state, answer registered
		next_st.pready = psel & penable & ~st.pready;
		next_st.pslverr = 1'b0;
		next_st.prdata = '0;
		if (psel & penable & ~st.pready) begin
			next_st.prdata = pwrite ? 32'h00000000 : rd_val;
			next_st.pslverr = ~rd_hit;
		end

		if (wr && paddr == `SFM_OFS_THR)
			next_st.thr_pend = pwdata[15:0];
		// pending threshold applies only with enable off, never on reset request
		if (!en_on)
			next_st.thr = st.thr_pend;

		// fault latches; a detector still high wins over a reset
		for (int i = 0; i < N_SRC; i++) begin
			if (alarm_m[i])
				next_st.act[i] = det_in[i];
			else if (det_in[i])
				next_st.act[i] = 1'b1;
			else if (rst_req && res_m[i] && !en_on)
				next_st.act[i] = 1'b0;
		end
		next_st.pend = st.pend & ~(N_SRC'(rec) << rec_idx);
		next_st.pend = next_st.pend | (next_st.act & ~st.act);

		// history, newest in entry 0; reset request never touches it
		if (clr_req)
			next_st.hvalid = '0;
		if (rec && !dup) begin
			next_st.hist = {st.hist[HIST_DEPTH-2:0], rec_code, snap_in};
			next_st.hvalid = {next_st.hvalid[HIST_DEPTH-2:0], 1'b1};
		end

		// most severe active code, lowest code on a tie
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (st.act[i] && (best == SFM_CAT_NONE || cat_of(code_of(i)) <= best)) begin
				best = cat_of(code_of(i));
				best_i = i;
			end
		end
		if (best == SFM_CAT_NONE) begin
			next_st.code = '0;
			next_st.bus = '0;
		end else begin
			next_st.code = code_of(best_i);
			next_st.bus = bus_of(best_i);
		end

		next_st.fault = |(st.act & ~alarm_m);
		next_st.warn = |(st.act & alarm_m);
		next_st.ready = power_ok_in & ~|(st.act & ~alarm_m);
		next_st.rot = spd_mag >= {1'b0, st.thr};
		next_st.brake = en_on & power_ok_in & ~|(st.act & ~alarm_m);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign servo_ready_out = st.ready;
	assign motor_rotating_out = st.rot;
	assign brake_out = st.brake;
	assign warn_out = st.warn;
	assign fault_out = st.fault;
	assign internal_fault_code_obj = st.code;
	assign bus_error_code_obj = st.bus;

	a_nonres_hold:
	assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (~st.act & $past(st.act) & nonres_m) == '0)
		else $error("non-resettable fault cleared");

	a_reset_needs_off:
	assert property (@(posedge pclk) disable iff (!presetn)
		st.en_sync[1] |=> (~st.act & $past(st.act) & ~alarm_m) == '0)
		else $error("fault cleared while enabled");

	a_log_kept:
	assert property (@(posedge pclk) disable iff (!presetn)
		(rst_req && !clr_req && st.hvalid[0]) |=> st.hvalid[0])
		else $error("reset request erased log");

	a_log_cleared:
	assert property (@(posedge pclk) disable iff (!presetn)
		(clr_req && !rec) |=> st.hvalid == '0)
		else $error("clear log left entries");

	a_dup_once:
	assert property (@(posedge pclk) disable iff (!presetn)
		(rec && dup && !clr_req) |=> st.hist == $past(st.hist) && st.hvalid == $past(st.hvalid))
		else $error("duplicate fault logged twice");

	a_fault_level:
	assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> fault_out == |($past(st.act) & ~alarm_m))
		else $error("fault output wrong");

	a_warn_level:
	assert property (@(posedge pclk) disable iff (!presetn)
		(det_in & alarm_m) == '0 |=> ##1 !warn_out)
		else $error("warning did not clear");

	a_rot_level:
	assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> motor_rotating_out == ($past(spd_mag) >= {1'b0, $past(st.thr)}))
		else $error("rotating output wrong");

	a_thr_frozen:
	assert property (@(posedge pclk) disable iff (!presetn)
		st.en_sync[1] |=> st.thr == $past(st.thr))
		else $error("threshold changed while enabled");

	a_ready_fault:
	assert property (@(posedge pclk) disable iff (!presetn)
		fault_out |-> !servo_ready_out)
		else $error("ready while fault");

	a_order_low:
	assert property (@(posedge pclk) disable iff (!presetn)
		(rec && !dup && !clr_req) |=> st.hist[0].code == code_of(lowest($past(st.pend))))
		else $error("log order wrong");

	a_alarm_follow:
	assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> (st.act & alarm_m) == ($past(det_in) & alarm_m))
		else $error("alarm latch not following detector");

	a_res_cleared:
	assert property (@(posedge pclk) disable iff (!presetn)
		(rst_req && !st.en_sync[1]) |=> (st.act & res_m & ~$past(det_in)) == '0)
		else $error("resettable fault survived reset");

	a_code_none:
	assert property (@(posedge pclk) disable iff (!presetn)
		st.act == '0 |=> internal_fault_code_obj == '0 && bus_error_code_obj == '0)
		else $error("code shown with no active fault");

	a_brake_fault:
	assert property (@(posedge pclk) disable iff (!presetn)
		fault_out |-> !brake_out)
		else $error("brake released while fault");

	a_pready_pulse:
	assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held past one cycle");

endmodule : sfm_fault_mgr

// ### sfm_fault_mgr_bench.sv
// self-checking bench of the servo fault manager: apb host, pins, detector model
// assumes the one-wait-state apb slave and register map of the fault manager
`timescale 1ns/1ps
`include "sfm_map.svh"
module sfm_fault_mgr_bench;
	import sfm_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, servo_en, p1, p2;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, rdy, rot, brk, warn, flt, pok;
	logic [19:0] det;
	logic [15:0] snap, s;
	logic signed [15:0] speed;
	sfm_code_t code;
	sfm_bus_t busc;
	logic [32:0] expq[$];
	int fails, cmp_count, seed, i;
	logic [11:0] ctab[7] = '{12'h010, 12'h011, 12'h020, 12'h021, 12'h022, 12'h053, 12'h060};
	logic [15:0] btab[7] = '{16'h6100, 16'h7122, 16'h6100, 16'h6100, 16'h6100, 16'h7500, 16'h8400};
	int itab[7] = '{0, 1, 2, 3, 4, 12, 13};
	sfm_detectors PART (.pclk(pclk), .det(det), .snap(snap), .speed(speed), .power_ok(pok));
	sfm_fault_mgr DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .det_in(det), .snap_in(snap), .speed_in(speed), .power_ok_in(pok),
		.servo_en_in(servo_en), .probe_one_in(p1), .probe_two_in(p2), .servo_ready_out(rdy),
		.motor_rotating_out(rot), .brake_out(brk), .warn_out(warn), .fault_out(flt),
		.internal_fault_code_obj(code), .bus_error_code_obj(busc));
	task end_sim;
		if (fails == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	// one transfer; read results are noted for the monitor
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			expq.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fails++;
			end_sim();
		end else begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask : rd
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr
	task rst;
		presetn <= 1'b0;
		tick(6);
		presetn <= 1'b1;
		tick(1);
	endtask : rst
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk("apb read", {pslverr, prdata}, expq.pop_front());
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, servo_en, p1, p2} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		fails = 0;
		cmp_count = 0;
		seed = 57255;
		rst();
		for (i = 0; i < 7; i++) begin
			s = 16'($random(seed));
			PART.put(20'h1 << itab[i], s, 16'sh0000);
			tick(5);
			chk("fault_out", flt, 1'b1);
			chk("servo_ready_out", rdy, 1'b0);
			rd(`SFM_OFS_CODE, {20'h0, ctab[i]});
			rd(`SFM_OFS_BUSC, {16'h0, btab[i]});
			PART.put(20'h0, s, 16'sh0000);
			tick(3);
			wr(`SFM_OFS_CTRL, 32'h1);
			tick(3);
			rd(`SFM_OFS_CODE, {20'h0, ctab[i]});
			rd(`SFM_OFS_HIST, {4'h0, ctab[i], s});
			rst();
		end
		tick(3);
		chk("servo_ready_out", rdy, 1'b1);
		s = 16'($random(seed));
		PART.put(20'h50000, s, 16'sh0000);
		tick(5);
		rd(`SFM_OFS_CODE, 32'h400);
		rd(`SFM_OFS_ACT, 32'h00050000);
		rd(`SFM_OFS_HIST, {4'h0, 12'h800, s});
		rd(`SFM_OFS_HIST + 12'h004, {4'h0, 12'h400, s});
		PART.put(20'h0, s, 16'sh0000);
		servo_en <= 1'b1;
		tick(4);
		wr(`SFM_OFS_CTRL, 32'h1);
		tick(3);
		chk("fault_out", flt, 1'b1);
		servo_en <= 1'b0;
		tick(4);
		wr(`SFM_OFS_CTRL, 32'h1);
		tick(3);
		chk("fault_out", flt, 1'b0);
		rd(`SFM_OFS_CODE, 32'h0);
		rd(`SFM_OFS_HIST, {4'h0, 12'h800, s});
		PART.put(20'h10000, s, 16'sh0000);
		tick(5);
		rd(`SFM_OFS_HIST, {4'h0, 12'h800, s});
		rd(`SFM_OFS_HIST + 12'h008, 32'h0);
		wr(`SFM_OFS_CTRL, 32'h2);
		tick(2);
		rd(`SFM_OFS_HIST, 32'h0);
		PART.put(20'h80000, s, 16'sh0000);
		tick(4);
		chk("warn_out", warn, 1'b1);
		PART.put(20'h0, s, 16'sh0000);
		tick(4);
		chk("warn_out", warn, 1'b0);
		wr(`SFM_OFS_CTRL, 32'h1);
		wr(`SFM_OFS_THR, 32'd100);
		PART.put(20'h0, s, 16'sd50);
		tick(4);
		chk("motor_rotating_out", rot, 1'b0);
		PART.put(20'h0, s, -16'sd100);
		tick(3);
		chk("motor_rotating_out", rot, 1'b1);
		servo_en <= 1'b1;
		p1 <= 1'b1;
		p2 <= 1'b1;
		tick(4);
		wr(`SFM_OFS_THR, 32'd200);
		tick(3);
		chk("motor_rotating_out", rot, 1'b1);
		chk("brake_out", brk, 1'b1);
		PART.set_power(1'b0);
		tick(2);
		chk("servo_ready_out", rdy, 1'b0);
		chk("brake_out", brk, 1'b0);
		rd(`SFM_OFS_STAT, 32'h000101D0);
		rd(`SFM_OFS_THR, 32'd200);
		apb(1'b0, 12'h01C, 32'h0, {1'b1, 32'h0});
		tick(2);
		end_sim();
	end
endmodule : sfm_fault_mgr_bench

// ### sfm_map.svh
// register offsets, field positions and sizes of the servo fault manager
// assumes byte addresses on a 32-bit apb bus, one word per register
`ifndef SFM_MAP_SVH
`define SFM_MAP_SVH
`define SFM_NSRC 20
`define SFM_HIST 10
`define SFM_DUP_WIN 5
`define SFM_OFS_CTRL 12'h000
`define SFM_OFS_THR 12'h004
`define SFM_OFS_STAT 12'h008
`define SFM_OFS_CODE 12'h00C
`define SFM_OFS_BUSC 12'h010
`define SFM_OFS_ACT 12'h014
`define SFM_OFS_HIST 12'h020
`define SFM_BIT_RST 0
`define SFM_BIT_CLR 1
`define SFM_STAT_HV 16
`define SFM_GRP_RES 4'h4
`define SFM_GRP_CAT2 4'h8
`define SFM_GRP_ALM 4'hD
`endif

// ### sfm_pkg.sv
// types shared by the servo fault manager
// assumes sfm_map.svh supplies the sizes
`include "sfm_map.svh"
package sfm_pkg;
	typedef logic [11:0] sfm_code_t;
	typedef logic [15:0] sfm_bus_t;
	typedef enum logic [1:0] {SFM_CAT_NONE, SFM_CAT1, SFM_CAT2, SFM_CAT3} sfm_cat_e;
	typedef struct packed {
		sfm_code_t code;
		sfm_bus_t bus;
	} sfm_info_s;
	typedef struct packed {
		sfm_code_t code;
		logic [15:0] snap;
	} sfm_hist_s;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [1:0] en_sync;
		logic [1:0] p1_sync;
		logic [1:0] p2_sync;
		logic [`SFM_NSRC-1:0] act;
		logic [`SFM_NSRC-1:0] pend;
		sfm_hist_s [`SFM_HIST-1:0] hist;
		logic [`SFM_HIST-1:0] hvalid;
		logic [15:0] thr_pend;
		logic [15:0] thr;
		sfm_code_t code;
		sfm_bus_t bus;
		logic fault;
		logic warn;
		logic ready;
		logic rot;
		logic brake;
	} sfm_state_s;
endpackage : sfm_pkg
